// ---- common/iac_pkg.sv ----
// Constants and types shared by the input active area calibration block.
package iac_pkg;
  localparam int DW = 16;
  localparam int AW = 8;
  localparam int NR = 4;
  localparam int NENT = 4;

  // Register offsets on the host port.
  localparam logic [AW-1:0] OFS_CTRL   = 8'h00;
  localparam logic [AW-1:0] OFS_STATUS = 8'h04;
  localparam logic [AW-1:0] OFS_INDEX  = 8'h08;
  localparam logic [AW-1:0] OFS_DATA   = 8'h0c;

  // Bit positions in the control and status registers.
  localparam int BIT_MANUAL  = 0;
  localparam int BIT_RESET   = 1;
  localparam int BIT_UPDATED = 2;
  localparam int BIT_TABLE   = 3;
  localparam int BIT_BEGUN   = 0;
  localparam int BIT_DONE    = 1;
  localparam int BIT_LOCKED  = 2;
  localparam int BIT_DEFAULT = 3;
  localparam int BIT_MANACT  = 4;

  // Ratio positions inside a calibration set.
  localparam int IDX_HSTART  = 0;
  localparam int IDX_HACTIVE = 1;
  localparam int IDX_VSTART  = 2;
  localparam int IDX_VACTIVE = 3;

  // Configuration index map.
  localparam logic [7:0] CFG_DEF    = 8'h00;
  localparam logic [7:0] CFG_MIN    = 8'h04;
  localparam logic [7:0] CFG_MAX    = 8'h08;
  localparam logic [7:0] CFG_MAN    = 8'h0c;
  localparam logic [7:0] CFG_LINES  = 8'h10;
  localparam logic [7:0] CFG_PIXELS = 8'h11;
  localparam logic [2:0] CFG_TABLE  = 3'h1;
  localparam logic [2:0] F_LINE     = 3'h0;
  localparam logic [2:0] F_PIXEL    = 3'h1;
  localparam logic [2:0] F_HACTIVE  = 3'h2;
  localparam logic [2:0] F_HSTART   = 3'h3;
  localparam logic [2:0] F_VACTIVE  = 3'h4;
  localparam logic [2:0] F_VSTART   = 3'h5;

  // Values of the configuration store after reset: default, min, max, manual.
  localparam logic [DW-1:0] RST_CFG [16] = '{
    16'h1000, 16'hc000, 16'h0800, 16'he000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'hffff, 16'hffff, 16'hffff, 16'hffff,
    16'h1000, 16'hc000, 16'h0800, 16'he000};

  // Timing figures and derived cycle and sample counts.
  localparam int CLK_KHZ = 40000;
  localparam int SAMPLE_MS = 50;
  localparam int SAMPLE_CYCLES = SAMPLE_MS * CLK_KHZ;
  localparam int STABLE_MS = 600;
  localparam int TIMEOUT_MS = 3000;
  localparam logic [7:0] STABLE_SAMPLES = 8'((STABLE_MS + SAMPLE_MS - 1) / SAMPLE_MS);
  localparam logic [7:0] TIMEOUT_SAMPLES = 8'(TIMEOUT_MS / SAMPLE_MS);
  localparam logic [7:0] MODE_SAMPLES = 8'h03;
  localparam logic [DW-1:0] MODE_TOL = 16'h0002;

  typedef logic [NR-1:0][DW-1:0] iac_ratios_t;

  typedef struct packed {
    logic [DW-1:0] horiz_start_measured;
    logic [DW-1:0] horiz_end_measured;
    logic [DW-1:0] vert_start_measured;
    logic [DW-1:0] vert_end_measured;
  } iac_edges_t;

  typedef struct packed {
    logic [DW-1:0] input_line_total;
    logic [DW-1:0] input_pixel_total;
  } iac_totals_t;

  typedef struct packed {
    logic [DW-1:0] table_entry_line_total;
    logic [DW-1:0] table_entry_pixel_total;
    iac_ratios_t   ratios;
  } iac_entry_t;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          wr;
    logic          rd;
  } iac_bus_t;

  typedef enum logic [2:0] {
    ST_RUN  = 3'b001,
    ST_CALC = 3'b010,
    ST_WAIT = 3'b100
  } iac_state_t;
endpackage : iac_pkg

// ---- rtl/iac_ratio_div.sv ----
// Sequential divider that forms numerator times two to the W over denominator.
module iac_ratio_div #(
  parameter int W = 16
) (
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  input  wire logic         start,
  input  wire logic [W-1:0] numer,
  input  wire logic [W-1:0] denom,
  output logic              done,
  output logic [W-1:0]      quot
);
  localparam int CW = $clog2(W) + 1;

  logic [W:0]    rem;
  logic [W:0]    next_rem;
  logic [W:0]    shifted;
  logic [W-1:0]  next_quot;
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic          busy;
  logic          next_busy;
  logic          next_done;

  // One quotient bit per cycle; a ratio of one or more saturates at once.
  always_comb begin
    next_rem = rem;
    next_quot = quot;
    next_cnt = cnt;
    next_busy = busy;
    next_done = 1'b0;
    shifted = {rem[W-1:0], 1'b0};
    if (start) begin
      if (numer >= denom) begin
        next_quot = '1;
        next_done = 1'b1;
        next_busy = 1'b0;
      end else begin
        next_rem = {1'b0, numer};
        next_quot = '0;
        next_cnt = '0;
        next_busy = 1'b1;
      end
    end else if (busy) begin
      if (shifted >= {1'b0, denom}) begin
        next_rem = shifted - {1'b0, denom};
        next_quot = {quot[W-2:0], 1'b1};
      end else begin
        next_rem = shifted;
        next_quot = {quot[W-2:0], 1'b0};
      end
      next_cnt = CW'(cnt + 1'b1);
      if (cnt == CW'(W - 1)) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end
    end
  end

  // Divider state registers.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rem <= '0;
      quot <= '0;
      cnt <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      rem <= next_rem;
      quot <= next_quot;
      cnt <= next_cnt;
      busy <= next_busy;
      done <= next_done;
    end
  end
endmodule : iac_ratio_div

// ---- rtl/iac_calibration.sv ----
// Input active area calibration: auto, manual and per-mode table sources.
module iac_calibration #(
  parameter int SAMPLE_CYC = iac_pkg::SAMPLE_CYCLES
) (
  input  wire logic          core_clk,
  input  wire logic          sys_rst,
  input  wire iac_pkg::iac_bus_t    bus,
  output logic [15:0]        bus_rdata,
  input  wire iac_pkg::iac_edges_t  edges,
  input  wire iac_pkg::iac_totals_t totals,
  output iac_pkg::iac_ratios_t      cal_ratios,
  output logic               cal_valid,
  output logic               mode_change_begun,
  output logic               mode_change_done
);
  import iac_pkg::*;

  iac_state_t    state, next_state;
  logic          manual_cal_select, next_manual_cal_select;
  logic          cal_table_enable, next_cal_table_enable;
  logic          manual_latched, next_manual_latched;
  logic [DW-1:0] cfg [16];
  logic [DW-1:0] next_cfg [16];
  iac_entry_t    tab [NENT];
  iac_entry_t    next_tab [NENT];
  logic [NENT-1:0] tab_valid, next_tab_valid;
  logic [1:0]    rr_ptr, next_rr_ptr;
  iac_ratios_t   next_cal_ratios, work, next_work, cand;
  logic          next_cal_valid, using_defaults, next_using_defaults;
  logic          next_begun, next_done;
  logic [7:0]    cfg_index, next_cfg_index;
  logic [DW-1:0] next_rdata, cfg_rd;
  logic [23:0]   tick_cnt, next_tick_cnt;
  logic [7:0]    stable_cnt, next_stable_cnt, timeout_cnt, next_timeout_cnt;
  logic [7:0]    mode_cnt, next_mode_cnt;
  iac_edges_t    prev, next_prev;
  logic          consumed, next_consumed;
  iac_totals_t   cand_tot, next_cand_tot, cur_tot, next_cur_tot;
  logic [1:0]    calc_idx, next_calc_idx;
  logic          div_start, next_div_start, div_done;
  logic [DW-1:0] div_numer, div_denom, div_quot;
  logic          sample_tick, far, mode_evt, reset_req, upd_req, in_range;
  logic          hit, have_old;
  logic [1:0]    hit_slot, store_slot;
  iac_totals_t   new_tot;
  logic [31:0]   cand_area, cur_area;

  // Host control strobes and the sample tick, each acting for one cycle only.
  assign reset_req = bus.wr && bus.addr == OFS_CTRL && bus.wdata[BIT_RESET];
  assign upd_req = bus.wr && bus.addr == OFS_CTRL && bus.wdata[BIT_UPDATED];
  assign sample_tick = tick_cnt == 24'(SAMPLE_CYC - 1);

  // Mode is considered changed when a total moves by more than the tolerance and holds the same value for MODE_SAMPLES samples.
  always_comb begin
    far = 1'b0;
    if (totals.input_line_total > cur_tot.input_line_total + MODE_TOL ||
        cur_tot.input_line_total > totals.input_line_total + MODE_TOL ||
        totals.input_pixel_total > cur_tot.input_pixel_total + MODE_TOL ||
        cur_tot.input_pixel_total > totals.input_pixel_total + MODE_TOL) begin
      far = 1'b1;
    end
  end
  assign mode_evt = sample_tick && far && totals == cand_tot &&
                    mode_cnt == MODE_SAMPLES - 8'h01;

  // Divider operand select: part over line or frame total.
  always_comb begin
    case (calc_idx)
      2'd0: div_numer = prev.horiz_start_measured;
      2'd1: div_numer = prev.horiz_end_measured - prev.horiz_start_measured;
      2'd2: div_numer = prev.vert_start_measured;
      default: div_numer = prev.vert_end_measured - prev.vert_start_measured;
    endcase
    div_denom = calc_idx[1] ? cur_tot.input_line_total : cur_tot.input_pixel_total;
  end

  iac_ratio_div #(
    .W (DW)
  ) iac_ratio_div_i (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .start    (div_start),
    .numer    (div_numer),
    .denom    (div_denom),
    .done     (div_done),
    .quot     (div_quot)
  );

  // Candidate set with the last quotient merged, checked against limits.
  always_comb begin
    cand = work;
    cand[calc_idx] = div_quot;
    in_range = 1'b1;
    for (int i = 0; i < NR; i++) begin
      if (cand[i] < cfg[CFG_MIN[3:0] + 4'(i)] || cand[i] > cfg[CFG_MAX[3:0] + 4'(i)]) begin
        in_range = 1'b0;
      end
    end
    cand_area = 32'(cand[IDX_HACTIVE]) * 32'(cand[IDX_VACTIVE]);
    cur_area = 32'(cal_ratios[IDX_HACTIVE]) * 32'(cal_ratios[IDX_VACTIVE]);
  end

  // Configuration read view through the index register.
  always_comb begin
    cfg_rd = '0;
    if (cfg_index < CFG_LINES) begin
      cfg_rd = cfg[cfg_index[3:0]];
    end else if (cfg_index == CFG_LINES) begin
      cfg_rd = cur_tot.input_line_total;
    end else if (cfg_index == CFG_PIXELS) begin
      cfg_rd = cur_tot.input_pixel_total;
    end else if (cfg_index[7:5] == CFG_TABLE) begin
      case (cfg_index[2:0])
        F_LINE:    cfg_rd = tab[cfg_index[4:3]].table_entry_line_total;
        F_PIXEL:   cfg_rd = tab[cfg_index[4:3]].table_entry_pixel_total;
        F_HACTIVE: cfg_rd = tab[cfg_index[4:3]].ratios[IDX_HACTIVE];
        F_HSTART:  cfg_rd = tab[cfg_index[4:3]].ratios[IDX_HSTART];
        F_VACTIVE: cfg_rd = tab[cfg_index[4:3]].ratios[IDX_VACTIVE];
        F_VSTART:  cfg_rd = tab[cfg_index[4:3]].ratios[IDX_VSTART];
        default:   cfg_rd = '0;
      endcase
    end
  end

  // Table slots: where the old mode is stored and where the new one is found.
  always_comb begin
    new_tot = mode_evt ? totals : cur_tot;
    have_old = 1'b0;
    store_slot = rr_ptr;
    for (int i = NENT - 1; i >= 0; i--) begin
      if (!tab_valid[i] && !have_old) begin
        store_slot = 2'(i);
      end
    end
    for (int i = 0; i < NENT; i++) begin
      if (tab_valid[i] && tab[i].table_entry_line_total == cur_tot.input_line_total &&
          tab[i].table_entry_pixel_total == cur_tot.input_pixel_total) begin
        store_slot = 2'(i);
        have_old = 1'b1;
      end
    end
    hit = 1'b0;
    hit_slot = '0;
    for (int i = 0; i < NENT; i++) begin
      if (tab_valid[i] && tab[i].table_entry_line_total == new_tot.input_line_total &&
          tab[i].table_entry_pixel_total == new_tot.input_pixel_total &&
          !(cal_table_enable && cal_valid && 2'(i) == store_slot)) begin
        hit = 1'b1;
        hit_slot = 2'(i);
      end
    end
  end

  // Next-state logic: host access first, hardware events after so they win.
  always_comb begin
    next_state = state;
    next_manual_cal_select = manual_cal_select;
    next_cal_table_enable = cal_table_enable;
    next_manual_latched = manual_latched;
    next_cfg = cfg;
    next_tab = tab;
    next_tab_valid = tab_valid;
    next_rr_ptr = rr_ptr;
    next_cal_ratios = cal_ratios;
    next_work = work;
    next_cal_valid = cal_valid;
    next_using_defaults = using_defaults;
    next_begun = mode_change_begun;
    next_done = mode_change_done;
    next_cfg_index = cfg_index;
    next_rdata = '0;
    next_tick_cnt = sample_tick ? '0 : 24'(tick_cnt + 1'b1);
    next_stable_cnt = stable_cnt;
    next_timeout_cnt = timeout_cnt;
    next_mode_cnt = mode_cnt;
    next_prev = prev;
    next_consumed = consumed;
    next_cand_tot = cand_tot;
    next_cur_tot = cur_tot;
    next_calc_idx = calc_idx;
    next_div_start = 1'b0;
    if (bus.rd) begin
      case (bus.addr)
        OFS_CTRL:   next_rdata = {12'h000, cal_table_enable, 2'b00, manual_cal_select};
        OFS_STATUS: next_rdata = {11'h000, manual_latched, using_defaults && cal_valid,
                                  cal_valid && !using_defaults && !manual_latched,
                                  mode_change_done, mode_change_begun};
        OFS_INDEX:  next_rdata = {8'h00, cfg_index};
        OFS_DATA:   next_rdata = cfg_rd;
        default:    next_rdata = '0;
      endcase
    end
    if (bus.wr) begin
      case (bus.addr)
        OFS_CTRL: begin
          next_manual_cal_select = bus.wdata[BIT_MANUAL];
          next_cal_table_enable = bus.wdata[BIT_TABLE];
        end
        OFS_STATUS: if (bus.wdata[BIT_DONE]) next_done = 1'b0;
        OFS_INDEX: next_cfg_index = bus.wdata[7:0];
        OFS_DATA: begin
          if (cfg_index < CFG_LINES) begin
            next_cfg[cfg_index[3:0]] = bus.wdata;
          end else if (cfg_index[7:5] == CFG_TABLE && cfg_index[2:0] <= F_VSTART) begin
            next_tab_valid[cfg_index[4:3]] = 1'b1;
            case (cfg_index[2:0])
              F_LINE:    next_tab[cfg_index[4:3]].table_entry_line_total = bus.wdata;
              F_PIXEL:   next_tab[cfg_index[4:3]].table_entry_pixel_total = bus.wdata;
              F_HACTIVE: next_tab[cfg_index[4:3]].ratios[IDX_HACTIVE] = bus.wdata;
              F_HSTART:  next_tab[cfg_index[4:3]].ratios[IDX_HSTART] = bus.wdata;
              F_VACTIVE: next_tab[cfg_index[4:3]].ratios[IDX_VACTIVE] = bus.wdata;
              default:   next_tab[cfg_index[4:3]].ratios[IDX_VSTART] = bus.wdata;
            endcase
          end
        end
        default: next_cfg_index = cfg_index;
      endcase
    end
    // Mode detection on each sample tick.
    if (sample_tick) begin
      if (!far) begin
        next_mode_cnt = '0;
      end else if (totals != cand_tot) begin
        next_cand_tot = totals;
        next_mode_cnt = '0;
      end else if (mode_cnt != MODE_SAMPLES) begin
        next_mode_cnt = 8'(mode_cnt + 1'b1);
      end
    end
    // Manual values picked up on the host's update flag.
    if (upd_req && manual_latched) begin
      for (int i = 0; i < NR; i++) next_cal_ratios[i] = cfg[CFG_MAN[3:0] + 4'(i)];
      next_cal_valid = 1'b1;
    end
    // Auto sampling of the measured edges while calibration runs unattended.
    if (state == ST_RUN && !manual_latched && sample_tick) begin
      if (edges == prev) begin
        if (stable_cnt != STABLE_SAMPLES) next_stable_cnt = 8'(stable_cnt + 1'b1);
      end else begin
        next_prev = edges;
        next_stable_cnt = '0;
        next_consumed = 1'b0;
      end
      if (!cal_valid && timeout_cnt != TIMEOUT_SAMPLES) begin
        next_timeout_cnt = 8'(timeout_cnt + 1'b1);
      end
    end
    case (state)
      ST_RUN: begin
        if (!manual_latched && stable_cnt == STABLE_SAMPLES && !consumed) begin
          next_consumed = 1'b1;
          next_calc_idx = '0;
          next_state = ST_CALC;
        end else if (!manual_latched && !cal_valid && timeout_cnt == TIMEOUT_SAMPLES) begin
          for (int i = 0; i < NR; i++) next_cal_ratios[i] = cfg[CFG_DEF[3:0] + 4'(i)];
          next_cal_valid = 1'b1;
          next_using_defaults = 1'b1;
        end
      end
      ST_CALC: begin
        next_div_start = 1'b1;
        next_state = ST_WAIT;
      end
      ST_WAIT: begin
        if (div_done) begin
          next_work = cand;
          if (calc_idx != 2'd3) begin
            next_calc_idx = 2'(calc_idx + 1'b1);
            next_state = ST_CALC;
          end else begin
            next_state = ST_RUN;
            if (!in_range) begin
              if (!cal_valid) begin
                for (int i = 0; i < NR; i++) next_cal_ratios[i] = cfg[CFG_DEF[3:0] + 4'(i)];
                next_cal_valid = 1'b1;
                next_using_defaults = 1'b1;
              end
            end else if (!cal_valid || using_defaults || cand_area > cur_area) begin
              next_cal_ratios = cand;
              next_cal_valid = 1'b1;
              next_using_defaults = 1'b0;
            end
          end
        end
      end
      default: next_state = ST_RUN;
    endcase
    // Mode change or calibration reset restarts acquisition.
    if (mode_evt || reset_req) begin
      next_begun = 1'b1;
      next_done = 1'b0;
      next_manual_latched = manual_cal_select;
      next_cur_tot = new_tot;
      next_mode_cnt = '0;
      next_cal_valid = 1'b0;
      next_using_defaults = 1'b0;
      next_stable_cnt = '0;
      next_timeout_cnt = '0;
      next_consumed = 1'b0;
      next_state = ST_RUN;
      if (reset_req) begin
        for (int i = 0; i < NENT; i++) begin
          if (tab[i].table_entry_line_total == cur_tot.input_line_total &&
              tab[i].table_entry_pixel_total == cur_tot.input_pixel_total) begin
            next_tab_valid[i] = 1'b0;
          end
        end
      end else if (cal_table_enable && cal_valid) begin
        next_tab[store_slot] = {cur_tot, cal_ratios};
        next_tab_valid[store_slot] = 1'b1;
        if (!have_old && tab_valid[store_slot]) next_rr_ptr = 2'(rr_ptr + 1'b1);
      end
      if (cal_table_enable && hit && !reset_req) begin
        next_cal_ratios = tab[hit_slot].ratios;
        next_cal_valid = 1'b1;
        if (manual_cal_select) begin
          for (int i = 0; i < NR; i++) next_cfg[CFG_MAN[3:0] + 4'(i)] = tab[hit_slot].ratios[i];
        end
      end else if (manual_cal_select) begin
        for (int i = 0; i < NR; i++) next_cal_ratios[i] = cfg[CFG_MAN[3:0] + 4'(i)];
        next_cal_valid = 1'b1;
      end
    end else if (mode_change_begun && cal_valid) begin
      next_begun = 1'b0;
      next_done = 1'b1;
    end
  end

  // State registers.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_RUN;
      manual_cal_select <= 1'b0;
      cal_table_enable <= 1'b0;
      manual_latched <= 1'b0;
      cfg <= RST_CFG;
      tab <= '{default: '0};
      tab_valid <= '0;
      rr_ptr <= '0;
      cal_ratios <= '0;
      work <= '0;
      cal_valid <= 1'b0;
      using_defaults <= 1'b0;
      mode_change_begun <= 1'b0;
      mode_change_done <= 1'b0;
      cfg_index <= '0;
      bus_rdata <= '0;
      tick_cnt <= '0;
      stable_cnt <= '0;
      timeout_cnt <= '0;
      mode_cnt <= '0;
      prev <= '0;
      consumed <= 1'b0;
      cand_tot <= '0;
      cur_tot <= '0;
      calc_idx <= '0;
      div_start <= 1'b0;
    end else begin
      state <= next_state;
      manual_cal_select <= next_manual_cal_select;
      cal_table_enable <= next_cal_table_enable;
      manual_latched <= next_manual_latched;
      cfg <= next_cfg;
      tab <= next_tab;
      tab_valid <= next_tab_valid;
      rr_ptr <= next_rr_ptr;
      cal_ratios <= next_cal_ratios;
      work <= next_work;
      cal_valid <= next_cal_valid;
      using_defaults <= next_using_defaults;
      mode_change_begun <= next_begun;
      mode_change_done <= next_done;
      cfg_index <= next_cfg_index;
      bus_rdata <= next_rdata;
      tick_cnt <= next_tick_cnt;
      stable_cnt <= next_stable_cnt;
      timeout_cnt <= next_timeout_cnt;
      mode_cnt <= next_mode_cnt;
      prev <= next_prev;
      consumed <= next_consumed;
      cand_tot <= next_cand_tot;
      cur_tot <= next_cur_tot;
      calc_idx <= next_calc_idx;
      div_start <= next_div_start;
    end
  end
endmodule : iac_calibration

// ---- dv/iac_video_src.sv ----
// Video source model feeding measured totals and active-video edges.
module iac_video_src
  import iac_pkg::*;
(
  input  wire logic           core_clk,
  input  wire logic           mode,
  input  wire logic           jitter,
  output iac_pkg::iac_edges_t  edges,
  output iac_pkg::iac_totals_t totals
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] cnt = 3'h0;
  // Free counter that makes a jittering edge differ on every sample.
  always_ff @(posedge core_clk) begin
    cnt <= cnt + 3'h1;
  end
  // Mode one doubles both totals, so every ratio halves.
  assign totals = '{16'h0200 << mode, 16'h0400 << mode};
  assign edges = '{16'h0080 + 16'(jitter ? cnt : 3'h0), 16'h0280, 16'h0040, 16'h0140};
endmodule : iac_video_src

// ---- dv/iac_calibration_asserts.sv ----
// Port checker for the calibration block.
module iac_calibration_asserts
  import iac_pkg::*;
#(
  parameter int SAMPLE_CYC = 10
) (
  input wire logic                core_clk,
  input wire logic                sys_rst,
  input wire iac_pkg::iac_bus_t    bus,
  input wire logic [15:0]         bus_rdata,
  input wire iac_pkg::iac_edges_t  edges,
  input wire iac_pkg::iac_totals_t totals,
  input wire iac_pkg::iac_ratios_t cal_ratios,
  input wire logic                cal_valid,
  input wire logic                mode_change_begun,
  input wire logic                mode_change_done
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LIM = 90 * SAMPLE_CYC;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  property p_rd_idle; !$past(bus.rd) |-> bus_rdata == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_stat; $past(bus.rd) && $past(bus.addr) == OFS_STATUS
    |-> bus_rdata[1:0] == {$past(mode_change_done), $past(mode_change_begun)}; endproperty
  a_stat: assert property (p_stat) else $error("status bits wrong");
  property p_done; $rose(cal_valid) |=> mode_change_done; endproperty
  a_done: assert property (p_done) else $error("done not set");
  property p_end; $rose(cal_valid) |=> !mode_change_begun; endproperty
  a_end: assert property (p_end) else $error("begun not cleared");
  property p_beg; $rose(mode_change_begun) |-> !mode_change_done; endproperty
  a_beg: assert property (p_beg) else $error("done with begun");
  property p_tot; $rose(mode_change_begun) && !$past(bus.wr)
    |-> $past(totals, 8) == totals; endproperty
  a_tot: assert property (p_tot) else $error("mode on unstable totals");
  property p_bound; $rose(mode_change_begun) |-> ##[1:LIM] cal_valid; endproperty
  a_bound: assert property (p_bound) else $error("no calibration in time");
  property p_fall; $fell(mode_change_done) |-> mode_change_begun || $past(bus.wr); endproperty
  a_fall: assert property (p_fall) else $error("done dropped alone");
  c_lock: cover property ($rose(cal_valid));
  c_mode: cover property ($rose(mode_change_begun));
  c_clear: cover property ($fell(mode_change_done));
endmodule : iac_calibration_asserts
bind iac_calibration iac_calibration_asserts #(.SAMPLE_CYC(SAMPLE_CYC)) iac_calibration_asserts_i (
  .core_clk(core_clk), .sys_rst(sys_rst), .bus(bus), .bus_rdata(bus_rdata),
  .edges(edges), .totals(totals), .cal_ratios(cal_ratios), .cal_valid(cal_valid),
  .mode_change_begun(mode_change_begun), .mode_change_done(mode_change_done));

// ---- dv/iac_calibration_test.sv ----
// Testbench for the calibration block.
module iac_calibration_test;
  timeunit 1ns;
  timeprecision 100ps;
  import iac_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic mode = 1'b0;
  logic jitter = 1'b0;
  iac_bus_t bus = '0;
  logic [15:0] bus_rdata, v;
  iac_edges_t edges;
  iac_totals_t totals;
  iac_ratios_t cal_ratios;
  logic cal_valid, mode_change_begun, mode_change_done;
  int miscompares = 0;
  int comparisons = 0;
  localparam iac_ratios_t M0 = {16'h8000, 16'h2000, 16'h8000, 16'h2000};
  localparam iac_ratios_t DEF = {16'he000, 16'h0800, 16'hc000, 16'h1000};
  localparam iac_ratios_t MA = {16'h4444, 16'h3333, 16'h2222, 16'h1111};
  localparam iac_ratios_t MB = {16'h4040, 16'h3030, 16'h2020, 16'h1010};
  always #12.5 core_clk = ~core_clk;
  iac_calibration #(.SAMPLE_CYC(10)) iac_calibration_i (.core_clk(core_clk), .sys_rst(sys_rst),
    .bus(bus), .bus_rdata(bus_rdata), .edges(edges), .totals(totals), .cal_ratios(cal_ratios),
    .cal_valid(cal_valid), .mode_change_begun(mode_change_begun),
    .mode_change_done(mode_change_done));
  iac_video_src iac_video_src_i (.core_clk(core_clk), .mode(mode), .jitter(jitter),
    .edges(edges), .totals(totals));
  task automatic chk(input string n, input iac_ratios_t e, input iac_ratios_t g);
    comparisons++;
    if (g !== e) begin
      $display("[ERR] %s exp %h got %h", n, e, g);
      miscompares++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge core_clk);
    bus <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge core_clk);
    bus.rd <= 1'b0;
    #1 d = bus_rdata;
  endtask : rd
  task automatic cw(input logic [7:0] i, input logic [15:0] d);
    wr(OFS_INDEX, {8'h00, i});
    wr(OFS_DATA, d);
  endtask : cw
  task automatic cr(input logic [7:0] i, input logic [15:0] e);
    logic [15:0] d;
    wr(OFS_INDEX, {8'h00, i});
    rd(OFS_DATA, d);
    chk("config", e, d);
  endtask : cr
  // Waits for a settled calibration, then compares the ratios.
  task automatic wt(input iac_ratios_t e);
    int n = 0;
    repeat (2) @(posedge core_clk);
    #1;
    while (!(cal_valid === 1'b1 && mode_change_begun === 1'b0 && cal_ratios === e) &&
           n < 3000) begin
      @(posedge core_clk);
      #1 n++;
    end
    if (n >= 3000) begin
      $display("[ERR] settled exp 1 got %b", cal_valid && !mode_change_begun);
      miscompares++;
    end
    chk("ratios", e, cal_ratios);
  endtask : wt
  task automatic final_report;
    if (miscompares == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  // Main sequence: auto, fallback, manual and table scenarios.
  initial begin
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 16; i++) cr(8'(i), RST_CFG[i]);
    rd(8'h10, v);
    chk("unmapped", 0, v);
    wt(M0);
    rd(OFS_STATUS, v);
    chk("status", 16'h0006, v);
    cw(CFG_MAX, 16'h1000);
    wr(OFS_CTRL, 16'h0002);
    repeat (2) @(posedge core_clk);
    #1 chk("valid", 0, cal_valid);
    wt(DEF);
    rd(OFS_STATUS, v);
    chk("status", 16'h000a, v);
    cw(CFG_MAX, 16'hffff);
    jitter <= 1'b1;
    wr(OFS_CTRL, 16'h0002);
    wt(DEF);
    jitter <= 1'b0;
    wt(M0);
    for (int i = 0; i < 4; i++) cw(CFG_MAN + 8'(i), 16'h1111 * 16'(i + 1));
    wr(OFS_CTRL, 16'h0005);
    repeat (30) @(posedge core_clk);
    #1 chk("ratios", M0, cal_ratios);
    wr(OFS_CTRL, 16'h0003);
    wt(MA);
    rd(OFS_STATUS, v);
    chk("status", 16'h0012, v);
    wr(OFS_CTRL, 16'h0009);
    mode <= 1'b1;
    repeat (60) @(posedge core_clk);
    wt(MA);
    cr(CFG_LINES, 16'h0400);
    cr(8'h20, 16'h0200);
    cr(8'h22, 16'h2222);
    for (int i = 0; i < 4; i++) cw(CFG_MAN + 8'(i), 16'h1010 * 16'(i + 1));
    wr(OFS_CTRL, 16'h000d);
    wt(MB);
    mode <= 1'b0;
    repeat (60) @(posedge core_clk);
    wt(MA);
    cr(8'h2b, 16'h1010);
    final_report();
  end
  // Watchdog that ends a hung run.
  initial begin
    #500000;
    miscompares++;
    final_report();
  end
endmodule : iac_calibration_test
